// ==== common/pse_wd_pkg.sv ====
package pse_wd_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_GLOBAL_CMD = 8'h1a;
   localparam logic [7:0] ADDR_PART_ID = 8'h1b;
   localparam logic [7:0] ADDR_TAKEOVER = 8'h1c;
   localparam logic [7:0] ADDR_WD_COUNT = 8'h1e;
   localparam logic [7:0] ADDR_SWITCH_MODE = 8'h1f;
   localparam logic [7:0] ADDR_GATE_AC_PROG = 8'h23;
   localparam logic [7:0] ADDR_CURLIM_PROG = 8'h27;
   localparam logic [7:0] ADDR_MISC_CFG = 8'h17;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_CLEAR_ALL_INTERRUPTS_BIT = 7;
   localparam int CMD_SOFT_RST_BIT = 4;
   localparam int SM_WD_EN_BIT = 7;
   localparam int SM_IRQ_EN_BIT = 6;
   localparam int SM_AC_TEST_BIT = 4;
   localparam int PRG_DETECT_BYPASS_ALLOW_BIT = 4;
   localparam int MISC_INT_EN_BIT = 7;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_GLOBAL_CMD = 8'h00;
   localparam logic [7:0] RST_TAKEOVER = 8'h00;
   localparam logic [7:0] RST_WD_COUNT = 8'h00;
   localparam logic [7:0] RST_SWITCH_MODE = 8'h00;
   localparam logic [7:0] RST_GATE_AC_PROG = 8'h04;
   localparam logic [7:0] RST_CURLIM_PROG = 8'h47;
   localparam logic [7:0] RST_MISC_CFG = 8'hc0;
   // ----------------------------------------------------------------
   // port operating modes and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
   localparam logic [1:0] MODE_AUTO = 2'b11;
   localparam int CLK_MHZ = 200;
   localparam int WD_TICK_MS = 164;
   localparam int WD_TICK_CYCLES = WD_TICK_MS * 1000 * CLK_MHZ;
endpackage : pse_wd_pkg

// ==== hw/pse_watchdog_global_control.sv ====
`timescale 1ns/10ps
module pse_watchdog_global_control #(
   parameter int TICK_CYCLES = pse_wd_pkg::WD_TICK_CYCLES,
   parameter logic [4:0] PART_PART_IDENTITY_FIELD = 5'h0a, // arbitrary value
   parameter logic [2:0] SILICON_REV = 3'h1 // arbitrary value
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [3:0] pwr_on_req_in,
   input wire logic [3:0] mode_wr_req_in,
   input wire logic [7:0] mode_wr_data_in,
   input wire logic [3:0] gate_drive_in,
   input wire logic [3:0] power_good_in,
   input wire logic event_irq_in,
   output logic [3:0] pwr_on_grant_out,
   output logic [3:0] mode_wr_grant_out,
   output logic [7:0] port_mode_out,
   output logic [3:0] port_mode_force_out,
   output logic hw_control_out,
   output logic [3:0] port_soft_reset_out,
   output logic clear_events_out,
   output logic [3:0] gate_drive_out,
   output logic [3:0] power_good_status_out,
   output logic [2:0] gate_pullup_code_out,
   output logic [2:0] ac_threshold_code_out,
   output logic detect_bypass_allow_out,
   output logic osc_fail_ignore_out,
   output logic [3:0] current_limit_code_out,
   output logic irq_n_out
);
   import pse_wd_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] global_cmd_q;
   logic [3:0] takeover_q;
   logic [7:0] wd_count_q;
   logic [7:0] switch_mode_q;
   logic [7:0] gate_ac_q;
   logic [7:0] curlim_q;
   logic [7:0] misc_q;
   logic hw_ctrl_q;
   logic [31:0] tick_cnt_q;
   logic soft_rst_q;
   logic tick;
   logic expire;
   logic [3:0] refused;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = reg_wr_in && (a == off);
   endfunction : hit

   // watchdog enable and nonzero refresh decode, shared by several processes
   wire wd_en = switch_mode_q[SM_WD_EN_BIT];
   wire wd_reload = hit(reg_addr_in, ADDR_WD_COUNT) && (reg_wdata_in != 8'h00);

   // command pulses held one cycle, then self-clear
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         global_cmd_q <= RST_GLOBAL_CMD;
      end else if (hit(reg_addr_in, ADDR_GLOBAL_CMD) && !soft_rst_q) begin
         global_cmd_q <= reg_wdata_in;
      end else begin
         global_cmd_q <= 8'h00;
      end
   end

   // soft reset acts the cycle after the write
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= hit(reg_addr_in, ADDR_GLOBAL_CMD) && reg_wdata_in[CMD_SOFT_RST_BIT];
      end
   end

   assign clear_events_out = global_cmd_q[CMD_CLEAR_ALL_INTERRUPTS_BIT];
   assign port_soft_reset_out = global_cmd_q[3:0];

   // configuration registers; soft reset overrides any write
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         switch_mode_q <= RST_SWITCH_MODE;
         gate_ac_q <= RST_GATE_AC_PROG;
         curlim_q <= RST_CURLIM_PROG;
         misc_q <= RST_MISC_CFG;
      end else if (soft_rst_q) begin
         switch_mode_q <= RST_SWITCH_MODE;
         gate_ac_q <= RST_GATE_AC_PROG;
         curlim_q <= RST_CURLIM_PROG;
         misc_q <= RST_MISC_CFG;
      end else begin
         if (hit(reg_addr_in, ADDR_SWITCH_MODE)) begin
            switch_mode_q <= {reg_wdata_in[7:6], 1'b0, reg_wdata_in[4:0]};
         end
         if (hit(reg_addr_in, ADDR_GATE_AC_PROG)) begin
            gate_ac_q <= reg_wdata_in;
         end
         if (hit(reg_addr_in, ADDR_CURLIM_PROG)) begin
            curlim_q <= reg_wdata_in;
         end
         if (hit(reg_addr_in, ADDR_MISC_CFG)) begin
            misc_q <= reg_wdata_in;
         end
      end
   end

   // 164 ms tick divider, restarted by a reload so the first
   // decrement after a refresh is a full period away
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tick_cnt_q <= 32'h0;
      end else if (soft_rst_q || !wd_en || wd_reload || tick) begin
         tick_cnt_q <= 32'h0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
      end
   end
   assign tick = wd_en && (tick_cnt_q == 32'(TICK_CYCLES - 1));

   // watchdog count: reload wins over tick, holds at zero
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wd_count_q <= RST_WD_COUNT;
      end else if (soft_rst_q) begin
         wd_count_q <= RST_WD_COUNT;
      end else if (hit(reg_addr_in, ADDR_WD_COUNT)) begin
         wd_count_q <= reg_wdata_in;
      end else if (tick && wd_count_q != 8'h00) begin
         wd_count_q <= wd_count_q - 8'h01;
      end
   end

   // expiry: count stepped down to zero by the tick
   assign expire = tick && (wd_count_q == 8'h01) && !wd_reload;

   // hardware control held until watchdog disabled or count refreshed
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hw_ctrl_q <= 1'b0;
      end else if (soft_rst_q || !wd_en || wd_reload) begin
         hw_ctrl_q <= 1'b0;
      end else if (expire) begin
         hw_ctrl_q <= 1'b1;
      end
   end

   // takeover modes driven for one cycle at expiry
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         port_mode_out[2*p +: 2] = switch_mode_q[p] ? MODE_AUTO : MODE_SHUTDOWN;
      end
   end
   assign port_mode_force_out = {4{expire}};
   assign hw_control_out = hw_ctrl_q;

   // gating of software requests under hardware control
   assign pwr_on_grant_out = hw_ctrl_q ? 4'h0 : pwr_on_req_in;
   assign mode_wr_grant_out = hw_ctrl_q ? 4'h0 : mode_wr_req_in;
   assign refused = hw_ctrl_q ? pwr_on_req_in : 4'h0;

   // flag read strobe; the read mux samples the old flags on the same edge
   wire to_read = reg_rd_in && (reg_addr_in == ADDR_TAKEOVER);

   // takeover flags: set wins over clear-on-read
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         takeover_q <= RST_TAKEOVER[3:0];
      end else if (soft_rst_q) begin
         takeover_q <= RST_TAKEOVER[3:0];
      end else if (wd_en) begin
         takeover_q <= (to_read ? 4'h0 : takeover_q)
                       | {4{expire}}
                       | refused;
      end else if (to_read) begin
         takeover_q <= 4'h0;
      end
   end

   // ac test mode overrides gate and power-good paths
   always_comb begin
      if (switch_mode_q[SM_AC_TEST_BIT]) begin
         gate_drive_out = 4'h0;
         power_good_status_out = 4'hf;
      end else begin
         gate_drive_out = gate_drive_in;
         power_good_status_out = power_good_in;
      end
   end

   // programming fields to the analog side
   assign gate_pullup_code_out = gate_ac_q[7:5];
   assign ac_threshold_code_out = gate_ac_q[2:0];
   assign detect_bypass_allow_out = gate_ac_q[PRG_DETECT_BYPASS_ALLOW_BIT];
   assign osc_fail_ignore_out = gate_ac_q[3];
   assign current_limit_code_out = curlim_q[7:4];

   // open-drain style interrupt, active low
   assign irq_n_out = !(misc_q[MISC_INT_EN_BIT] &&
                        (event_irq_in || (switch_mode_q[SM_IRQ_EN_BIT] && |takeover_q)));

   // register read mux, unmapped reads zero
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            ADDR_PART_ID: reg_rdata_out <= {PART_PART_IDENTITY_FIELD, SILICON_REV};
            ADDR_TAKEOVER: reg_rdata_out <= {4'h0, takeover_q};
            ADDR_WD_COUNT: reg_rdata_out <= wd_count_q;
            ADDR_SWITCH_MODE: reg_rdata_out <= switch_mode_q;
            ADDR_GATE_AC_PROG: reg_rdata_out <= gate_ac_q;
            ADDR_CURLIM_PROG: reg_rdata_out <= curlim_q;
            ADDR_MISC_CFG: reg_rdata_out <= misc_q;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_cmd_write;
      hit(reg_addr_in, ADDR_GLOBAL_CMD) && !soft_rst_q;
   endsequence

   chk_cmd_self_clear: assert property (s_cmd_write ##1 !hit(reg_addr_in, ADDR_GLOBAL_CMD)
      |=> global_cmd_q == 8'h00)
      else $error("command bits did not self-clear");
   chk_clear_pulse: assert property (s_cmd_write ##0 reg_wdata_in[7] |=> clear_events_out)
      else $error("clear-all pulse missing");
   chk_soft_reset: assert property (soft_rst_q |=> switch_mode_q == 8'h00 && gate_ac_q == 8'h04)
      else $error("soft reset did not restore registers");
   chk_hold_zero: assert property (wd_count_q == 8'h00 && !hit(reg_addr_in, ADDR_WD_COUNT)
                                   |=> wd_count_q == 8'h00)
      else $error("watchdog count wrapped");
   chk_tick_dec: assert property (tick && wd_count_q != 8'h00 && !hit(reg_addr_in, ADDR_WD_COUNT)
                                  && !soft_rst_q |=> wd_count_q == $past(wd_count_q) - 8'h01)
      else $error("count did not decrement");
   chk_expire_flag: assert property (expire && !soft_rst_q |=> takeover_q == 4'hf && hw_ctrl_q)
      else $error("expiry did not set flags");
   chk_no_power_on: assert property (hw_ctrl_q |-> pwr_on_grant_out == 4'h0 &&
                                     mode_wr_grant_out == 4'h0)
      else $error("request granted under hardware control");
   chk_flag_gated: assert property (!wd_en && !to_read && !soft_rst_q
      |=> takeover_q == $past(takeover_q))
      else $error("flag changed with watchdog off");
   chk_ac_test: assert property (switch_mode_q[4] |-> gate_drive_out == 4'h0 &&
                                 power_good_status_out == 4'hf)
      else $error("ac test override missing");
   chk_irq_gate: assert property (!misc_q[7] |-> irq_n_out)
      else $error("interrupt driven while disabled");

   // ----------------------------------------------------------------
   // watchdog and takeover sequences
   // ----------------------------------------------------------------
   // last tick before zero, with no host write racing it
   sequence s_last_tick;
      tick && wd_count_q == 8'h01 && !hit(reg_addr_in, ADDR_WD_COUNT) && !soft_rst_q;
   endsequence

   // nonzero refresh of the count
   sequence s_reload;
      wd_reload && !soft_rst_q;
   endsequence

   // software power-on request arriving under hardware control
   sequence s_refused_req;
      hw_ctrl_q && wd_en && !soft_rst_q && pwr_on_req_in != 4'h0;
   endsequence

   // flag read with no setting event in the same cycle
   sequence s_flag_read;
      to_read && !expire && refused == 4'h0 && !soft_rst_q;
   endsequence

   // expiry: force pulse first, hardware control at zero next
   chk_expire_steps: assert property (s_last_tick |-> (port_mode_force_out == 4'hf)
      ##1 (hw_ctrl_q && wd_count_q == 8'h00))
      else $error("expiry did not enter hardware control");
   chk_force_idle: assert property (!expire |-> port_mode_force_out == 4'h0)
      else $error("mode force outside expiry");
   chk_mode_pick: assert property (port_mode_out ==
      {{2{switch_mode_q[3]}}, {2{switch_mode_q[2]}}, {2{switch_mode_q[1]}}, {2{switch_mode_q[0]}}})
      else $error("takeover mode encoding wrong");

   // refresh, refusal and read-clear of the flags
   chk_reload_restart: assert property (s_reload |=> wd_count_q == $past(reg_wdata_in) &&
      tick_cnt_q == 32'h0 && !hw_ctrl_q)
      else $error("nonzero write did not reload the count");
   chk_refused_flag: assert property (s_refused_req |=>
      (takeover_q & $past(pwr_on_req_in)) == $past(pwr_on_req_in))
      else $error("refused power-on did not set its flag");
   chk_read_clear: assert property (s_flag_read |=> takeover_q == 4'h0)
      else $error("takeover flags not cleared by read");
   chk_mode_locked: assert property (hw_ctrl_q |-> mode_wr_grant_out == 4'h0)
      else $error("mode change granted under hardware control");

   // interrupt, port reset, divider and identity
   chk_takeover_irq: assert property (misc_q[MISC_INT_EN_BIT] &&
      switch_mode_q[SM_IRQ_EN_BIT] && takeover_q != 4'h0 |-> !irq_n_out)
      else $error("takeover interrupt missing");
   chk_port_reset: assert property (s_cmd_write ##0 reg_wdata_in[3:0] != 4'h0
      |=> port_soft_reset_out == $past(reg_wdata_in[3:0]))
      else $error("port soft reset pulse missing");
   chk_tick_bound: assert property (tick_cnt_q < 32'(TICK_CYCLES))
      else $error("tick divider ran past its period");
   chk_id_read: assert property (reg_rd_in && reg_addr_in == ADDR_PART_ID
      |=> reg_rdata_out == {PART_PART_IDENTITY_FIELD, SILICON_REV})
      else $error("identity read returned wrong value");
endmodule : pse_watchdog_global_control

// ==== tb/pse_host_model.sv ====
`timescale 1ns/10ps
// ---------------------------------------------
// host side register access model
// ---------------------------------------------
module pse_host_model (
   input wire logic clk_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   input wire logic [7:0] reg_rdata_in
);
   // bus idle before the first access
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
   end
   // released bus shows inverted data so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
   endtask : wr
   // read data is registered, so it is taken one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      @(posedge clk_in);
      #1;
      d = reg_rdata_in;
   endtask : rd
endmodule : pse_host_model

// ==== tb/pse_watchdog_global_control_test.sv ====
`timescale 1ns/10ps
// ---------------------------------------------
// bench for global control and watchdog
// ---------------------------------------------
module pse_watchdog_global_control_test;
   import pse_wd_pkg::*;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic wr, rd;
   logic [7:0] addr, wdata, rdata, v;
   logic [3:0] pwr_req = 4'h0, mode_req = 4'h0, gate_in = 4'hf, pg_in = 4'h0;
   logic ev_irq = 1'b0;
   logic [3:0] grant, mgrant, srst, gate_out, pg_out, force_out, cl_code;
   logic [7:0] mode_out;
   logic hw_ctl, clr_ev, detect_bypass_allow, irq_n, osc;
   logic [2:0] pu_code, ac_code;
   int n_errors = 0, total_checks = 0, cycles = 0, n, nf;
   localparam logic [7:0] ID = {5'h0a, 3'h1}; // arbitrary value
   localparam int TICK = 10; // short tick keeps the run small
   always #2.5 clk_in = ~clk_in;
   pse_host_model u_pse_host_model (.clk_in(clk_in), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
   pse_watchdog_global_control #(.TICK_CYCLES(TICK), .PART_PART_IDENTITY_FIELD(5'h0a),
      .SILICON_REV(3'h1)) u_pse_watchdog_global_control (
      .clk_in(clk_in), .nrst_in(nrst_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .pwr_on_req_in(pwr_req), .mode_wr_req_in(mode_req), .mode_wr_data_in(8'h00),
      .gate_drive_in(gate_in), .power_good_in(pg_in), .event_irq_in(ev_irq),
      .pwr_on_grant_out(grant), .mode_wr_grant_out(mgrant), .port_mode_out(mode_out),
      .port_mode_force_out(force_out), .hw_control_out(hw_ctl),
      .port_soft_reset_out(srst), .clear_events_out(clr_ev), .gate_drive_out(gate_out),
      .power_good_status_out(pg_out), .gate_pullup_code_out(pu_code),
      .ac_threshold_code_out(ac_code), .detect_bypass_allow_out(detect_bypass_allow),
      .osc_fail_ignore_out(osc), .current_limit_code_out(cl_code), .irq_n_out(irq_n));
   // ---------------------------------------------
   // compare, report and close
   // ---------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   // cut a hang short well past the expected run length
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         test_done();
      end
   end
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset();
      u_pse_host_model.rd(ADDR_SWITCH_MODE, v); check(v, 8'h00);
      u_pse_host_model.rd(ADDR_GATE_AC_PROG, v); check(v, 8'h04);
      u_pse_host_model.rd(ADDR_WD_COUNT, v); check(v, 8'h00);
      u_pse_host_model.rd(ADDR_TAKEOVER, v); check(v, 8'h00);
      check({4'h0, cl_code}, 8'h04);
      u_pse_host_model.wr(ADDR_PART_ID, 8'hff);
      u_pse_host_model.rd(ADDR_PART_ID, v); check(v, ID);
   endtask : t_reset
   // the clear-all bit and port reset bits 0 and 3 must each show as exactly one pulse cycle
   task automatic t_cmd();
      u_pse_host_model.wr(ADDR_GLOBAL_CMD, 8'h80);
      n = 0;
      repeat (4) begin
         #1 n += (clr_ev === 1'b1);
         @(posedge clk_in);
      end
      check(8'(n), 8'h01);
      u_pse_host_model.wr(ADDR_GLOBAL_CMD, 8'h09);
      n = 0;
      repeat (4) begin
         #1 n += (srst === 4'h9);
         @(posedge clk_in);
      end
      check(8'(n), 8'h01);
   endtask : t_cmd
   task automatic t_watchdog();
      u_pse_host_model.wr(ADDR_SWITCH_MODE, 8'hc5);
      u_pse_host_model.wr(ADDR_WD_COUNT, 8'h02);
      u_pse_host_model.rd(ADDR_WD_COUNT, v); check(v, 8'h02);
      repeat (8) @(posedge clk_in);
      u_pse_host_model.rd(ADDR_WD_COUNT, v); check(v, 8'h01);
      u_pse_host_model.wr(ADDR_WD_COUNT, 8'h02);
      repeat (15) @(posedge clk_in);
      #1 check({7'h0, hw_ctl}, 8'h00);
      n = 0;
      nf = 0;
      while (hw_ctl !== 1'b1 && n < 100) begin
         @(posedge clk_in);
         #1 n++;
         nf += (force_out === 4'hf);
      end
      check(8'(n), 8'(2 * TICK - 15));
      check(8'(nf), 8'h01);
      check({7'h0, hw_ctl}, 8'h01);
      check(mode_out, 8'h33);
      check({7'h0, irq_n}, 8'h00);
      u_pse_host_model.rd(ADDR_TAKEOVER, v); check(v, 8'h0f);
      u_pse_host_model.rd(ADDR_TAKEOVER, v); check(v, 8'h00);
      @(posedge clk_in);
      pwr_req <= 4'h2;
      mode_req <= 4'h4;
      #1 check({grant, mgrant}, 8'h00);
      @(posedge clk_in);
      pwr_req <= 4'h0;
      mode_req <= 4'h0;
      u_pse_host_model.rd(ADDR_TAKEOVER, v); check(v, 8'h02);
   endtask : t_watchdog
   // a fresh refused request leaves a flag standing for the reset to wipe
   task automatic t_soft_reset();
      @(posedge clk_in);
      pwr_req <= 4'h1;
      @(posedge clk_in);
      pwr_req <= 4'h0;
      u_pse_host_model.wr(ADDR_GATE_AC_PROG, 8'hb5);
      check({7'h0, irq_n}, 8'h00);
      u_pse_host_model.wr(ADDR_GLOBAL_CMD, 8'h10);
      u_pse_host_model.rd(ADDR_SWITCH_MODE, v); check(v, 8'h00);
      u_pse_host_model.rd(ADDR_TAKEOVER, v); check(v, 8'h00);
      u_pse_host_model.rd(ADDR_GATE_AC_PROG, v); check(v, 8'h04);
      check({7'h0, hw_ctl}, 8'h00);
   endtask : t_soft_reset
   task automatic t_program();
      u_pse_host_model.wr(ADDR_SWITCH_MODE, 8'h10);
      #1 check({gate_out, pg_out}, 8'h0f);
      u_pse_host_model.wr(ADDR_GATE_AC_PROG, 8'hb5);
      u_pse_host_model.rd(ADDR_GATE_AC_PROG, v); check(v, 8'hb5);
      check({5'h0, pu_code}, 8'h05);
      check({5'h0, ac_code}, 8'h05);
      check({7'h0, detect_bypass_allow}, 8'h01);
      check({7'h0, osc}, 8'h00);
      @(posedge clk_in);
      ev_irq <= 1'b1;
      #1 check({7'h0, irq_n}, 8'h00);
      u_pse_host_model.wr(ADDR_MISC_CFG, 8'h00);
      #1 check({7'h0, irq_n}, 8'h01);
   endtask : t_program
   // main sequence: reset held for three cycles
   initial begin
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_cmd();
      t_watchdog();
      t_soft_reset();
      t_program();
      test_done();
   end
endmodule : pse_watchdog_global_control_test
